// ===== temp_seq_consts.vh
// constants for the temperature conversion sequencer: register pointers,
// field positions, reset values and timing counts.
// assumes a 125 MHz core clock and a byte-wide register port fed by a serial slave.
//
// Behaviour
// - halt_request_bit at config1 bit 6 clear: convert continuously at programmed rate
// - halt bit set: finish running sequence, then stop converting and enter shutdown
// - clearing the halt bit leaves shutdown and resumes continuous conversions
// - config1 bit 2 selects standard or extended temperature range
// - config1 at pointer 09h is read/write and resets to 00h
// - status at 08h is read-only; bit 7 is busy, other bits zero
// - after reset the first conversion starts so busy rises within 100 us
// - in shutdown a one-shot write to 0Fh runs one sequence, then shutdown
// - data byte of a one-shot write is discarded and stored nowhere
// - a one-shot write during a conversion is ignored
// - series_res_corr_en in config2 at 0Ah enables resistance correction on remotes
// - with correction off each remote conversion takes about half the time; local is unchanged
// - config2 bit 3 local_chan_en enables the local channel
// - config2 bit 4 enables remote channel 1
// - config2 bit 5 remote2_chan_en exists only on the dual variant
// - order local, remote 1, remote 2, idle delay, repeat; disabled channels skipped
// - config2 resets to 1Ch single or 3Ch dual; bits 7,6,1,0 read zero
// - rate register at 0Bh sets only idle time, never conversion length
// - one-shot write during idle starts a new sequence at once
// - 3-bit rate code: 0.0625 per second doubling to 8; resets to 07h
// - a write with ptr_wr_i loads the pointer; reads return the pointed register
`ifndef TEMP_SEQ_CONSTS_VH
`define TEMP_SEQ_CONSTS_VH

// ==========================================================
// register pointers
`define PTR_STATUS        8'h08
`define PTR_CFG1          8'h09
`define PTR_CFG2          8'h0a
`define PTR_RATE          8'h0b
`define PTR_ONESHOT       8'h0f
`define PTR_RESET         8'h00

// ==========================================================
// field positions
`define CFG1_HALT_BIT     6
`define CFG1_RANGE_BIT    2
`define CFG1_MASK         8'h44
`define CFG2_SRC_BIT      2
`define CFG2_LOCAL_BIT    3
`define CFG2_REM1_BIT     4
`define CFG2_REM2_BIT     5
`define CFG2_MASK_SINGLE  8'h1c
`define CFG2_MASK_DUAL    8'h3c
`define STATUS_BUSY_BIT   7
`define RATE_MASK         8'h07

// ==========================================================
// reset values
`define CFG1_RST          8'h00
`define CFG2_RST_SINGLE   8'h1c
`define CFG2_RST_DUAL     8'h3c
`define RATE_RST          8'h07
`define BYTE_ZERO         8'h00

// ==========================================================
// timing: clock 125 MHz; slowest idle is 16 s (0.0625 per second)
`define CLK_HZ            125000000
`define POWERUP_MAX_US    100
`define POWERUP_CYC       ((`POWERUP_MAX_US * (`CLK_HZ / 1000000)))
`define CONV_CYC_DEF      2500000
`define PERIOD_8HZ_CYC    (`CLK_HZ / 8)
`define CNT_W             32
`define RATE_MAX_CODE     3'h7

`endif

// ===== chan_picker.v
// picks the next enabled channel at or after a given slot.
// assumes a three-slot sequence: local, remote 1, remote 2; slot code 3 means none left.
`timescale 1ns/1ps
`default_nettype none
module chan_picker (
  input  wire [1:0] from_i,
  input  wire [2:0] en_i,
  output reg  [1:0] next_o
);
  // skip disabled channels in fixed order
  always @* begin
    next_o = 2'h3;
    if (from_i == 2'h0 && en_i[0]) begin
      next_o = 2'h0;
    end else if (from_i <= 2'h1 && en_i[1]) begin
      next_o = 2'h1;
    end else if (from_i <= 2'h2 && en_i[2]) begin
      next_o = 2'h2;
    end
  end
endmodule
`default_nettype wire

// ===== step_timer.v
// down-counter used for conversion steps and idle delay.
// assumes load and count come from the same clock domain; clock enable freezes it.
`timescale 1ns/1ps
`default_nettype none
`include "temp_seq_consts.vh"
module step_timer (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire                ce_i,
  input  wire                load_i,
  input  wire [`CNT_W-1:0]   value_i,
  output wire                done_o
);
  reg [`CNT_W-1:0] cnt_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= {`CNT_W{1'b0}};
    end else if (ce_i) begin
      if (load_i) begin
        cnt_q <= value_i;
      end else if (cnt_q != {`CNT_W{1'b0}}) begin
        cnt_q <= cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign done_o = (cnt_q == {`CNT_W{1'b0}});
endmodule
`default_nettype wire

// ===== temp_conversion_sequencer.v
// conversion sequencer with its register set behind a byte-wide pointer port.
// assumes a serial slave on the same clock presents whole bytes: wr_i with
// ptr_wr_i says the byte is a pointer, otherwise data for the pointed register.
`timescale 1ns/1ps
`default_nettype none
`include "temp_seq_consts.vh"
module temp_conversion_sequencer #(
  parameter DUAL_REMOTE = 1,
  parameter CONV_CYC    = `CONV_CYC_DEF,
  parameter IDLE_BASE   = `PERIOD_8HZ_CYC
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire       wr_i,
  input  wire       ptr_wr_i,
  input  wire [7:0] wdata_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  output reg        busy_o,
  output reg        halted_o,
  output reg        range_ext_o,
  output reg  [1:0] chan_o,
  output reg        conv_start_o,
  output reg        src_en_o
);

  // ==========================================================
  // states
  localparam [2:0] ST_START = 3'h0;
  localparam [2:0] ST_CONV  = 3'h1;
  localparam [2:0] ST_NEXT  = 3'h2;
  localparam [2:0] ST_IDLE  = 3'h3;
  localparam [2:0] ST_HALT  = 3'h4;

  localparam [7:0] CFG2_MASK = DUAL_REMOTE ? `CFG2_MASK_DUAL : `CFG2_MASK_SINGLE;
  localparam [7:0] CFG2_RST  = DUAL_REMOTE ? `CFG2_RST_DUAL : `CFG2_RST_SINGLE;
  localparam [`CNT_W-1:0] CONV_FULL = CONV_CYC;
  localparam [`CNT_W-1:0] CONV_HALF = CONV_CYC / 2;

  function is_ptr;
    input [7:0] p;
    input [7:0] a;
    begin
      is_ptr = (p == a);
    end
  endfunction

  // ==========================================================
  // registers
  reg [7:0] ptr_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] rate_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] slot_q;
  reg [1:0] slot_d;
  reg       oneshot_q;
  reg       oneshot_d;
  reg       load;
  reg [`CNT_W-1:0] load_val;
  wire      tmr_done;
  wire [1:0] pick;
  reg [1:0] pick_from;

  wire data_wr  = wr_i && !ptr_wr_i;
  wire halt_bit = cfg1_q[`CFG1_HALT_BIT];
  wire [2:0] chan_en = {cfg2_q[`CFG2_REM2_BIT], cfg2_q[`CFG2_REM1_BIT], cfg2_q[`CFG2_LOCAL_BIT]};
  // one-shot only honoured outside a conversion step
  wire oneshot_hit = data_wr && is_ptr(ptr_q, `PTR_ONESHOT)
                     && (state_q == ST_IDLE || state_q == ST_HALT);

  // idle after a sequence: 8 Hz period shifted up by (7 - code)
  wire [2:0] rate_code = rate_q[2:0];
  wire [2:0] rate_shift = `RATE_MAX_CODE - rate_code;
  wire [`CNT_W-1:0] idle_cyc = IDLE_BASE << rate_shift;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_q  <= `PTR_RESET;
      cfg1_q <= `CFG1_RST;
      cfg2_q <= CFG2_RST;
      rate_q <= `RATE_RST;
    end else if (ce_i) begin
      if (wr_i && ptr_wr_i) begin
        ptr_q <= wdata_i;
      end
      if (data_wr) begin
        if (is_ptr(ptr_q, `PTR_CFG1)) begin
          cfg1_q <= wdata_i & `CFG1_MASK;
        end
        if (is_ptr(ptr_q, `PTR_CFG2)) begin
          cfg2_q <= wdata_i & CFG2_MASK;
        end
        if (is_ptr(ptr_q, `PTR_RATE)) begin
          rate_q <= wdata_i & `RATE_MASK;
        end
        // one-shot data byte is dropped on purpose
      end
    end
  end

  // ==========================================================
  // sequencer
  chan_picker u_pick (
    .from_i (pick_from),
    .en_i   (chan_en),
    .next_o (pick)
  );

  step_timer u_tmr (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .load_i  (load),
    .value_i (load_val),
    .done_o  (tmr_done)
  );

  // remotes take half as long without correction; local is unaffected
  wire [`CNT_W-1:0] step_len = (pick != 2'h0 && !cfg2_q[`CFG2_SRC_BIT]) ? CONV_HALF : CONV_FULL;

  always @* begin
    state_d   = state_q;
    slot_d    = slot_q;
    oneshot_d = oneshot_q;
    load      = 1'b0;
    load_val  = step_len;
    pick_from = 2'h0;
    case (state_q)
      ST_START: begin
        pick_from = 2'h0;
        if (pick == 2'h3) begin
          // nothing enabled: go straight to the end of the sequence
          state_d = ST_NEXT;
        end else begin
          slot_d  = pick;
          load    = 1'b1;
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        pick_from = slot_q + 2'h1;
        if (tmr_done) begin
          if (pick == 2'h3) begin
            state_d = ST_NEXT;
          end else begin
            slot_d  = pick;
            load    = 1'b1;
          end
        end
      end
      ST_NEXT: begin
        // sequence finished: halt wins over the rate delay
        if (halt_bit || oneshot_q) begin
          oneshot_d = 1'b0;
          state_d   = ST_HALT;
        end else begin
          load     = 1'b1;
          load_val = idle_cyc;
          state_d  = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (oneshot_hit) begin
          state_d = ST_START;
        end else if (halt_bit) begin
          state_d = ST_HALT;
        end else if (tmr_done) begin
          state_d = ST_START;
        end
      end
      ST_HALT: begin
        if (!halt_bit) begin
          state_d = ST_START;
        end else if (oneshot_hit) begin
          oneshot_d = 1'b1;
          state_d   = ST_START;
        end
      end
      default: begin
        state_d = ST_START;
      end
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q   <= ST_START;
      slot_q    <= 2'h0;
      oneshot_q <= 1'b0;
    end else if (ce_i) begin
      state_q   <= state_d;
      slot_q    <= slot_d;
      oneshot_q <= oneshot_d;
    end
  end

  // ==========================================================
  // registered outputs and read port
  wire busy_d = (state_d == ST_CONV);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o      <= `BYTE_ZERO;
      busy_o       <= 1'b0;
      halted_o     <= 1'b0;
      range_ext_o  <= 1'b0;
      chan_o       <= 2'h0;
      conv_start_o <= 1'b0;
      src_en_o     <= 1'b0;
    end else if (ce_i) begin
      busy_o       <= busy_d;
      halted_o     <= (state_d == ST_HALT);
      range_ext_o  <= cfg1_q[`CFG1_RANGE_BIT];
      chan_o       <= slot_d;
      conv_start_o <= load && (state_d == ST_CONV);
      src_en_o     <= cfg2_q[`CFG2_SRC_BIT];
      if (rd_i) begin
        if (is_ptr(ptr_q, `PTR_STATUS)) begin
          rdata_o <= {busy_o, 7'h00};
        end else if (is_ptr(ptr_q, `PTR_CFG1)) begin
          rdata_o <= cfg1_q;
        end else if (is_ptr(ptr_q, `PTR_CFG2)) begin
          rdata_o <= cfg2_q;
        end else if (is_ptr(ptr_q, `PTR_RATE)) begin
          rdata_o <= rate_q;
        end else begin
          rdata_o <= `BYTE_ZERO;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== temp_seq_checker_sva.sv
// port checker for the conversion sequencer
// assumes one clock and an async active-high reset
`timescale 1ns/1ps
`default_nettype none
module temp_seq_checker (
  input wire       clk_i,
  input wire       rst_i,
  input wire       ce_i,
  input wire       wr_i,
  input wire       ptr_wr_i,
  input wire [7:0] wdata_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       busy_o,
  input wire       halted_o,
  input wire       range_ext_o,
  input wire       conv_start_o,
  input wire       src_en_o
);
  // ========
  // pointer shadow, the real one is not visible at the ports
  logic [7:0] ptr_q;
  wire        dw  = wr_i & ce_i & ~ptr_wr_i;
  wire        rdp = rd_i & ce_i;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) ptr_q <= 8'h00;
    else if (wr_i & ce_i & ptr_wr_i) ptr_q <= wdata_i;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ========
  // properties
  property p_boot; $fell(rst_i) |-> ##[0:3] busy_o; endproperty
  a_boot: assert property (p_boot) else $error("busy late after reset");
  property p_start; conv_start_o |-> busy_o; endproperty
  a_start: assert property (p_start) else $error("step without busy");
  property p_gap; conv_start_o |=> !conv_start_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("step too short");
  property p_halt; $rose(halted_o) |-> !busy_o; endproperty
  a_halt: assert property (p_halt) else $error("halt inside a step");
  property p_resume; dw && ptr_q == 8'h09 && !wdata_i[6] && halted_o |-> ##[1:4] !halted_o; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  // the copy pins follow the config register one edge after it loads
  property p_range; dw && ptr_q == 8'h09 |=> ##1 range_ext_o == $past(wdata_i[2], 2); endproperty
  a_range: assert property (p_range) else $error("range bit");
  property p_src; dw && ptr_q == 8'h0a |=> ##1 src_en_o == $past(wdata_i[2], 2); endproperty
  a_src: assert property (p_src) else $error("correction bit");
  property p_stat; rdp && ptr_q == 8'h08 |=> rdata_o == {$past(busy_o), 7'h00}; endproperty
  a_stat: assert property (p_stat) else $error("status read");

  c_halt: cover property ($rose(halted_o));
  c_resume: cover property ($fell(halted_o));
  c_trig: cover property (dw && ptr_q == 8'h0f);
endmodule

bind temp_conversion_sequencer temp_seq_checker chk (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .ce_i         (ce_i),
  .wr_i         (wr_i),
  .ptr_wr_i     (ptr_wr_i),
  .wdata_i      (wdata_i),
  .rd_i         (rd_i),
  .rdata_o      (rdata_o),
  .busy_o       (busy_o),
  .halted_o     (halted_o),
  .range_ext_o  (range_ext_o),
  .conv_start_o (conv_start_o),
  .src_en_o     (src_en_o)
);
`default_nettype wire

// ===== host_model.sv
// host stand-in driving the register byte port
// assumes the bench clock; changes lines at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire        clk_i,
  input  wire        busy_i,
  input  wire  [7:0] rdata_i,
  output logic       wr_o,
  output logic       ptr_wr_o,
  output logic [7:0] wdata_o,
  output logic       rd_o
);
  initial {wr_o, ptr_wr_o, wdata_o, rd_o} = 11'h0a4;
  // released data lines show the inverse so stale bytes never pass
  task automatic put(input logic p, input logic [7:0] d);
    @(negedge clk_i) {wr_o, ptr_wr_o, wdata_o} = {1'b1, p, d};
    @(negedge clk_i) {wr_o, wdata_o} = {1'b0, ~d};
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a);
    put(1'b0, a == 8'h09 ? d & 8'h44 : d);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    put(1'b1, a);
    @(negedge clk_i) rd_o = 1'b1;
    @(negedge clk_i) rd_o = 1'b0;
    d = rdata_i;
  endtask
  task automatic one_shot(input logic [7:0] d);
    for (int k = 0; k < 400 && busy_i; k++) @(negedge clk_i);
    wr_reg(8'h0f, d);
  endtask
endmodule
`default_nettype wire

// ===== temp_conversion_sequencer_bench.sv
// self-checking bench for the conversion sequencer
// assumes short step and idle counts set below
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module temp_conversion_sequencer_bench;
  localparam int CONV = 20;
  localparam int BASE = 4;
  logic       clk_i = 0;
  logic       rst_i = 1;
  logic       ce = 1'b1;
  logic       wr, pw, rd, busy, halted, rng, cs, src;
  logic [7:0] wd, rdat, v;
  logic [1:0] chan;
  logic [1:0] ch[$];
  int         st[$];
  int         err_count = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         g, g5, g7;

  temp_conversion_sequencer #(.CONV_CYC(CONV), .IDLE_BASE(BASE)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wr_i(wr), .ptr_wr_i(pw), .wdata_i(wd), .rd_i(rd), .rdata_o(rdat), .busy_o(busy),
    .halted_o(halted), .range_ext_o(rng), .chan_o(chan), .conv_start_o(cs), .src_en_o(src));
  host_model host (.clk_i(clk_i), .busy_i(busy), .rdata_i(rdat), .wr_o(wr), .ptr_wr_o(pw),
    .wdata_o(wd), .rd_o(rd));

  initial forever #4 clk_i = ~clk_i;
  // ========
  // step log: cycle and channel of every step start
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cs) begin
      st.push_back(cyc);
      ch.push_back(chan);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic clr;
    st = {};
    ch = {};
  endtask
  // sequences are found by their first channel, since gaps alone cannot tell idle from a long step
  task automatic seq(input logic [7:0] c2, input logic [2:0] r, input int n, input logic [5:0] o, output int gap);
    int i;
    host.wr_reg(8'h0a, c2);
    host.wr_reg(8'h0b, {5'h00, r});
    clr();
    tick(4 * (3 * CONV + (BASE << (7 - r))));
    for (i = 1; i < st.size() - n && ch[i] !== o[1:0]; i++);
    for (int k = 0; k < n; k++) begin
      `CHK(ch[i+k], o[2*k+:2])
      // a step spans the loaded count plus the cycle that sees the timer run out
      if (k < n - 1)
        `CHK(st[i+k+1] - st[i+k], (o[2*k+:2] != 0 && !c2[2]) ? CONV / 2 + 1 : CONV + 1)
    end
    gap = st[i+n] - st[i+n-1];
  endtask
  // ========
  // scenarios
  task automatic t_reset;
    `CHK(busy, 1'b1)
    host.rd_reg(8'h09, v);
    `CHK(v, 8'h00)
    host.rd_reg(8'h0a, v);
    `CHK(v, 8'h3c)
    host.rd_reg(8'h0b, v);
    `CHK(v, 8'h07)
  endtask
  // clock enable low must freeze the step in flight and start nothing new
  task automatic t_freeze;
    logic       b;
    logic [1:0] c;
    while (cs) @(negedge clk_i);
    clr();
    ce = 1'b0;
    b = busy;
    c = chan;
    tick(3 * CONV);
    `CHK(st.size(), 0)
    `CHK(busy, b)
    `CHK(chan, c)
    ce = 1'b1;
    tick(3 * CONV);
    `CHK(st.size() != 0, 1'b1)
  endtask
  task automatic t_order;
    seq(8'h34, 3'd7, 2, 6'b00_10_01, g);
    seq(8'h2c, 3'd7, 2, 6'b00_10_00, g);
    seq(8'h1c, 3'd7, 2, 6'b00_01_00, g);
    seq(8'h3c, 3'd7, 3, 6'b10_01_00, g7);
    seq(8'h3c, 3'd5, 3, 6'b10_01_00, g5);
    `CHK(g5 - g7, 3 * BASE)
    seq(8'h38, 3'd7, 3, 6'b10_01_00, g);
    `CHK(g7 - g, CONV / 2)
  endtask
  task automatic t_halt;
    for (int k = 0; k < 200 && !(cs && chan == 2'd0); k++) @(negedge clk_i);
    // the log takes a start one edge after it shows, so let it take this one first
    tick(1);
    clr();
    host.wr_reg(8'h09, 8'h44);
    tick(4 * CONV);
    `CHK(ch[1], 2'd2)
    `CHK(halted, 1'b1)
    `CHK(rng, 1'b1)
    host.one_shot(8'hff);
    tick(4 * CONV);
    `CHK(st.size(), 5)
    `CHK(halted, 1'b1)
    host.rd_reg(8'h09, v);
    `CHK(v, 8'h44)
    host.one_shot(8'h00);
    tick(CONV / 2);
    host.wr_reg(8'h0f, 8'h00);
    tick(4 * CONV);
    `CHK(st.size(), 8)
    host.wr_reg(8'h09, 8'h00);
    tick(CONV);
    `CHK(halted, 1'b0)
  endtask
  task automatic t_idle;
    host.wr_reg(8'h0b, 8'h00);
    tick(4 * CONV);
    host.rd_reg(8'h08, v);
    `CHK(v, 8'h00)
    clr();
    host.wr_reg(8'h0f, 8'h00);
    tick(4);
    `CHK(st.size(), 1)
    host.rd_reg(8'h08, v);
    `CHK(v, 8'h80)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(8 * 20000);
    err_count++;
    final_report();
  end
  initial begin
    tick(3);
    rst_i = 1'b0;
    tick(2);
    t_reset();
    t_freeze();
    t_order();
    t_halt();
    t_idle();
    final_report();
  end
endmodule
`default_nettype wire
